/* File: design/opd_control.sv */
// Summary of operation
// RULE1: Fetch the pair only while memory is not regenerating; stall otherwise.
// RULE2: Advance the control counter by one after each pair fetch.
// RULE3: Execute the left order, digits 0 to 19, first.
// RULE4: Instruction digits feed decode register; address goes to memory, counter or shifter.
// RULE5: Memory-operand orders read the operand into the number register before execution.
// RULE6: A control transfer loads the counter only after the order finishes.
// RULE7: Shift orders send the address field to the shift count, not memory.
// RULE8: Non-transfer left order is followed by right order, address moved to 10-19.
// RULE9: After both orders, fetch the next pair from the control counter.
// RULE10: Each order is a five-digit code: instruction plus three-digit address.
// RULE11: Two-digit codes: program places instruction digits before the address.
// RULE12: Three-digit codes: program adds address arithmetically to the instruction.
// RULE13: Clearing load orders clear accumulator then add, subtract or absolute.
// RULE14: Accumulating variants do the same without clearing the accumulator.
// RULE15: The operand-register load clears that register then adds the operand.
// RULE16: Register-to-accumulator loads then jump; a left one runs right order first.
// RULE17: The unused digit 9 or 29 of an order is ignored.
// RULE18: Busy holds from fetch start until the right order completes; the code drops it when a left transfer order finishes.
`timescale 1ns/1ps
`default_nettype none
module opd_control
  import opd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic mem_regen_in,
  input wire logic mem_ack_in,
  input wire logic [WORD_W-1:0] mem_rdata_in,
  input wire logic arith_done_in,
  output opd_mem_req_t mem_req_out,
  output opd_exec_t exec_out,
  output logic [INSTR_W-1:0] instruction_decode_register_out,
  output logic [ADDR_W-1:0] cc_out,
  output logic busy_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  opd_state_t state, next_state;
  logic [WORD_W-1:0] order_pair_register, next_order_pair_register;
  logic [ADDR_W-1:0] cc, next_cc;
  logic right_half, next_right_half;
  logic start_right, next_start_right;
  logic pend_jump, next_pend_jump;
  logic [ADDR_W-1:0] pend_addr, next_pend_addr;
  logic [INSTR_W-1:0] idr, next_idr;
  opd_dec_t dec_q, next_dec_q;
  opd_mem_req_t mem_req, next_mem_req;
  opd_exec_t exec_q, next_exec_q;
  logic busy, next_busy;
  logic [ORDER_W-1:0] cur_order;
  opd_dec_t dec_now;

  // Step the counter by one, wrapping within the address range
  function automatic logic [ADDR_W-1:0] cc_inc(input logic [ADDR_W-1:0] v);
    cc_inc = v + CC_STEP;
  endfunction

  // ---------------------------------------------------------------
  // Order selection and decode
  // ---------------------------------------------------------------
  // Right order is decoded from its own half; address always from 10-19
  assign cur_order = right_half ? order_pair_register[RIGHT_MSB:RIGHT_LSB]
                                : order_pair_register[LEFT_MSB:LEFT_LSB]; // RULE3

  // Digit 9 is never looked at: only instruction digits reach the decoder
  opd_order_decode u_dec (
    .instr_in(cur_order[INSTR_MSB:INSTR_LSB]), // RULE17
    .dec_out(dec_now)
  );

  // ---------------------------------------------------------------
  // Sequencer next values
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_order_pair_register = order_pair_register;
    next_cc = cc;
    next_right_half = right_half;
    next_start_right = start_right;
    next_pend_jump = pend_jump;
    next_pend_addr = pend_addr;
    next_idr = idr;
    next_dec_q = dec_q;
    next_mem_req = mem_req;
    next_exec_q = exec_q;
    next_exec_q.start = 1'b0;
    next_busy = busy;
    case (state)
      ST_FETCH: begin
        // Wait out regeneration before asking for the pair
        if (!mem_regen_in) begin
          next_mem_req.rd = 1'b1; // RULE1
          next_mem_req.addr = cc; // RULE9
          next_busy = 1'b1; // RULE18
          next_state = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        if (mem_ack_in) begin
          next_mem_req.rd = 1'b0;
          next_order_pair_register = mem_rdata_in;
          // Entering at the right order needs its address in 10-19 at once
          if (start_right) begin
            next_order_pair_register[LEFT_LSB+ADDR_MSB:LEFT_LSB+ADDR_LSB] =
              mem_rdata_in[RIGHT_LSB+ADDR_MSB:RIGHT_LSB+ADDR_LSB]; // RULE8
          end
          next_cc = cc_inc(cc); // RULE2
          next_right_half = start_right;
          next_start_right = 1'b0;
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // Instruction digits into the decode register, address routed
        next_idr = cur_order[INSTR_MSB:INSTR_LSB]; // RULE4
        next_dec_q = dec_now;
        next_exec_q.instr = cur_order[INSTR_MSB:INSTR_LSB];
        next_exec_q.dec = dec_now;
        next_exec_q.addr = order_pair_register[LEFT_LSB+ADDR_MSB:LEFT_LSB+ADDR_LSB]; // RULE10
        next_exec_q.shift_n = '0;
        if (dec_now.cls == CLS_SHIFT) begin
          next_exec_q.shift_n = order_pair_register[LEFT_LSB+SHIFT_W-1:LEFT_LSB]; // RULE7
          next_state = ST_EXEC;
        end else if (dec_now.cls == CLS_MEM) begin
          next_state = ST_OPREQ; // RULE4
        end else begin
          next_state = ST_EXEC;
        end
      end
      ST_OPREQ: begin
        if (!mem_regen_in) begin
          next_mem_req.rd = 1'b1; // RULE1
          next_mem_req.addr = exec_q.addr; // RULE4
          next_state = ST_OPWAIT;
        end
      end
      ST_OPWAIT: begin
        if (mem_ack_in) begin
          next_mem_req.rd = 1'b0;
          next_exec_q.operand = mem_rdata_in; // RULE5
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_exec_q.start = 1'b1;
        next_state = ST_XWAIT;
      end
      ST_XWAIT: begin
        if (arith_done_in) begin
          next_state = ST_NEXT;
        end
      end
      ST_NEXT: begin
        // Transfers take effect here, after the order has finished
        if (dec_q.cls == CLS_JUMP_L || dec_q.cls == CLS_JUMP_R) begin
          next_cc = exec_q.addr; // RULE6
          next_start_right = (dec_q.cls == CLS_JUMP_R);
          next_pend_jump = 1'b0;
          next_busy = 1'b0;
          next_state = ST_FETCH;
        end else if (!right_half) begin
          // Move right address into 10-19 and decode the right order
          next_order_pair_register[LEFT_LSB+ADDR_MSB:LEFT_LSB+ADDR_LSB] =
            order_pair_register[RIGHT_LSB+ADDR_MSB:RIGHT_LSB+ADDR_LSB]; // RULE8
          next_right_half = 1'b1;
          if (dec_q.jump_after) begin
            next_pend_jump = 1'b1; // RULE16
            next_pend_addr = exec_q.addr;
          end
          next_state = ST_DECODE;
        end else begin
          if (dec_q.jump_after) begin
            next_cc = exec_q.addr; // RULE16
          end else if (pend_jump) begin
            next_cc = pend_addr; // RULE6
          end
          next_pend_jump = 1'b0;
          next_busy = 1'b0; // RULE18
          next_state = ST_FETCH; // RULE9
        end
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state <= ST_FETCH;
      order_pair_register <= '0;
      cc <= CC_RESET;
      right_half <= 1'b0;
      start_right <= 1'b0;
      pend_jump <= 1'b0;
      pend_addr <= '0;
      idr <= '0;
      dec_q <= '0;
      mem_req <= '0;
      exec_q <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      order_pair_register <= next_order_pair_register;
      cc <= next_cc;
      right_half <= next_right_half;
      start_right <= next_start_right;
      pend_jump <= next_pend_jump;
      pend_addr <= next_pend_addr;
      idr <= next_idr;
      dec_q <= next_dec_q;
      mem_req <= next_mem_req;
      exec_q <= next_exec_q;
      busy <= next_busy;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign mem_req_out = mem_req;
  assign exec_out = exec_q;
  assign instruction_decode_register_out = idr;
  assign cc_out = cc;
  assign busy_out = busy;

endmodule
`default_nettype wire

/* File: design/opd_pkg.sv */
package opd_pkg;

  // ---------------------------------------------------------------
  // Word and order layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 40;
  localparam int ORDER_W = 20;
  localparam int INSTR_W = 9;
  localparam int ADDR_W = 10;
  localparam int SHIFT_W = 6;
  // Bit positions inside a 20-bit order, digit k sits at bit 19-k
  localparam int INSTR_MSB = 19;
  localparam int INSTR_LSB = 11;
  localparam int ADDR_MSB = 9;
  localparam int ADDR_LSB = 0;
  // Halves of the order pair word
  localparam int LEFT_MSB = 39;
  localparam int LEFT_LSB = 20;
  localparam int RIGHT_MSB = 19;
  localparam int RIGHT_LSB = 0;
  localparam logic [ADDR_W-1:0] CC_RESET = 10'h000;
  localparam logic [ADDR_W-1:0] CC_STEP = 10'h001;

  // ---------------------------------------------------------------
  // Instruction codes, nine instruction digits
  // ---------------------------------------------------------------
  localparam logic [INSTR_W-1:0] OP_CLR_ADD = 9'h1ea;
  localparam logic [INSTR_W-1:0] OP_CLR_SUB = 9'h1e2;
  localparam logic [INSTR_W-1:0] OP_CLR_ADD_ABS = 9'h1ee;
  localparam logic [INSTR_W-1:0] OP_CLR_SUB_ABS = 9'h1e6;
  localparam logic [INSTR_W-1:0] OP_ACC_ADD = 9'h1e8;
  localparam logic [INSTR_W-1:0] OP_ACC_SUB = 9'h1e0;
  localparam logic [INSTR_W-1:0] OP_ACC_ADD_ABS = 9'h1ec;
  localparam logic [INSTR_W-1:0] OP_ACC_SUB_ABS = 9'h1e4;
  localparam logic [INSTR_W-1:0] OP_MQ_LOAD = 9'h1e1;
  localparam logic [INSTR_W-1:0] OP_MQ_ADD_J = 9'h06b;
  localparam logic [INSTR_W-1:0] OP_MQ_SUB_J = 9'h063;
  localparam logic [INSTR_W-1:0] OP_MQ_ADD_ABS_J = 9'h06f;
  localparam logic [INSTR_W-1:0] OP_MQ_SUB_ABS_J = 9'h067;
  localparam logic [INSTR_W-1:0] OP_JUMP_LEFT = 9'h048;
  localparam logic [INSTR_W-1:0] OP_CLR_JUMP_LEFT = 9'h04a;
  localparam logic [INSTR_W-1:0] OP_JUMP_RIGHT = 9'h140;
  localparam logic [INSTR_W-1:0] OP_SHL = 9'h000;
  localparam logic [INSTR_W-1:0] OP_SHL_HALF = 9'h012;
  localparam logic [INSTR_W-1:0] OP_SHL_CLR = 9'h002;
  localparam logic [INSTR_W-1:0] OP_SHR = 9'h020;
  localparam logic [INSTR_W-1:0] OP_SHR_HALF = 9'h032;
  localparam logic [INSTR_W-1:0] OP_SHR_CLR = 9'h022;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_MEM = 3'h0,
    CLS_SHIFT = 3'h1,
    CLS_JUMP_L = 3'h2,
    CLS_JUMP_R = 3'h3,
    CLS_NONE = 3'h4
  } opd_class_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_FWAIT = 3'b001,
    ST_DECODE = 3'b011,
    ST_OPREQ = 3'b010,
    ST_OPWAIT = 3'b110,
    ST_EXEC = 3'b111,
    ST_XWAIT = 3'b101,
    ST_NEXT = 3'b100
  } opd_state_t;

  typedef struct packed {
    opd_class_t cls;
    logic jump_after;
    logic clr_acc;
    logic clr_mq;
    logic negate;
    logic absval;
    logic to_mq;
    logic from_mq;
    logic shift_right;
    logic half_ins;
  } opd_dec_t;

  typedef struct packed {
    logic start;
    logic [INSTR_W-1:0] instr;
    opd_dec_t dec;
    logic [ADDR_W-1:0] addr;
    logic [SHIFT_W-1:0] shift_n;
    logic [WORD_W-1:0] operand;
  } opd_exec_t;

  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
  } opd_mem_req_t;

endpackage

/* File: design/opd_order_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module opd_order_decode
  import opd_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_in,
  output opd_dec_t dec_out
);

  // ---------------------------------------------------------------
  // Instruction digit decode into gate and clear controls
  // ---------------------------------------------------------------
  always_comb begin
    dec_out = '0;
    dec_out.cls = CLS_MEM;
    case (instr_in)
      OP_CLR_ADD, OP_CLR_SUB, OP_CLR_ADD_ABS, OP_CLR_SUB_ABS: begin
        dec_out.clr_acc = 1'b1; // RULE13
        dec_out.negate = (instr_in == OP_CLR_SUB) || (instr_in == OP_CLR_SUB_ABS);
        dec_out.absval = (instr_in == OP_CLR_ADD_ABS) || (instr_in == OP_CLR_SUB_ABS);
      end
      OP_ACC_ADD, OP_ACC_SUB, OP_ACC_ADD_ABS, OP_ACC_SUB_ABS: begin
        dec_out.negate = (instr_in == OP_ACC_SUB) || (instr_in == OP_ACC_SUB_ABS); // RULE14
        dec_out.absval = (instr_in == OP_ACC_ADD_ABS) || (instr_in == OP_ACC_SUB_ABS);
      end
      OP_MQ_LOAD: begin
        dec_out.clr_mq = 1'b1; // RULE15
        dec_out.to_mq = 1'b1;
      end
      OP_MQ_ADD_J, OP_MQ_SUB_J, OP_MQ_ADD_ABS_J, OP_MQ_SUB_ABS_J: begin
        dec_out.cls = CLS_NONE; // RULE16
        dec_out.jump_after = 1'b1;
        dec_out.clr_acc = 1'b1;
        dec_out.from_mq = 1'b1;
        dec_out.negate = (instr_in == OP_MQ_SUB_J) || (instr_in == OP_MQ_SUB_ABS_J);
        dec_out.absval = (instr_in == OP_MQ_ADD_ABS_J) || (instr_in == OP_MQ_SUB_ABS_J);
      end
      OP_JUMP_LEFT, OP_CLR_JUMP_LEFT: begin
        dec_out.cls = CLS_JUMP_L;
        dec_out.clr_acc = (instr_in == OP_CLR_JUMP_LEFT);
      end
      OP_JUMP_RIGHT: begin
        dec_out.cls = CLS_JUMP_R;
      end
      OP_SHL, OP_SHL_HALF, OP_SHL_CLR, OP_SHR, OP_SHR_HALF, OP_SHR_CLR: begin
        dec_out.cls = CLS_SHIFT; // RULE7
        dec_out.shift_right = (instr_in == OP_SHR) || (instr_in == OP_SHR_HALF) ||
                              (instr_in == OP_SHR_CLR);
        dec_out.half_ins = (instr_in == OP_SHL_HALF) || (instr_in == OP_SHR_HALF);
        dec_out.clr_acc = dec_out.half_ins || (instr_in == OP_SHL_CLR) ||
                          (instr_in == OP_SHR_CLR);
      end
      default: begin
        dec_out.cls = CLS_MEM;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: sim/opd_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module opd_control_props
  import opd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic mem_regen_in,
  input wire logic mem_ack_in,
  input wire opd_mem_req_t mem_req_out,
  input wire opd_exec_t exec_out,
  input wire logic [INSTR_W-1:0] instruction_decode_register_out,
  input wire logic [ADDR_W-1:0] cc_out,
  input wire logic busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Read waiting for its answer
  sequence s_req_wait;
    mem_req_out.rd && !mem_ack_in;
  endsequence
  // Start of an order that takes a memory operand
  sequence s_mem_start;
    exec_out.start && exec_out.dec.cls == CLS_MEM;
  endsequence
  property p_regen_gate;
    $rose(mem_req_out.rd) |-> !$past(mem_regen_in);
  endproperty
  a_regen_gate: assert property (p_regen_gate) else $error("read during regen");
  property p_req_hold;
    s_req_wait |=> mem_req_out.rd && $stable(mem_req_out.addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("read not held");
  property p_req_drop;
    mem_req_out.rd && mem_ack_in |=> !mem_req_out.rd;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("read not released");
  property p_fetch_addr;
    $rose(busy_out) |-> mem_req_out.rd && mem_req_out.addr == cc_out;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not from counter");
  property p_start_pulse;
    exec_out.start |=> !exec_out.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_busy_exec;
    exec_out.start |-> busy_out;
  endproperty
  a_busy_exec: assert property (p_busy_exec) else $error("not busy in order");
  property p_dec_reg;
    exec_out.start |-> instruction_decode_register_out == exec_out.instr;
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("decode register differs");
  property p_shift_count;
    exec_out.start && exec_out.dec.cls == CLS_SHIFT |->
      exec_out.shift_n == exec_out.addr[SHIFT_W-1:0] && !mem_req_out.rd;
  endproperty
  a_shift_count: assert property (p_shift_count) else $error("bad shift count");
  property p_mem_operand;
    s_mem_start |-> $past(mem_ack_in, 2) || $past(mem_ack_in, 3);
  endproperty
  a_mem_operand: assert property (p_mem_operand) else $error("start without operand");
endmodule
bind opd_control opd_control_props u_props (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .mem_regen_in(mem_regen_in), .mem_ack_in(mem_ack_in), .mem_req_out(mem_req_out),
  .exec_out(exec_out), .instruction_decode_register_out(instruction_decode_register_out),
  .cc_out(cc_out), .busy_out(busy_out));
`default_nettype wire

/* File: sim/opd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module opd_mem_model
  import opd_pkg::*;
#(
  parameter int REGEN_P = 20
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic regen_en_in,
  input wire logic [3:0] lat_in,
  input wire opd_mem_req_t req_in,
  output logic regen_out,
  output logic ack_out,
  output logic [WORD_W-1:0] rdata_out
);
  logic [WORD_W-1:0] words [0:1023];
  logic [7:0] tick;
  logic [3:0] wait_n;
  // Regeneration bursts, answer after lat_in cycles, data scrambled when idle
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tick <= 8'h00;
      regen_out <= 1'b0;
      ack_out <= 1'b0;
      wait_n <= 4'h0;
      rdata_out <= '0;
    end else begin
      tick <= (tick == REGEN_P - 1) ? 8'h00 : tick + 8'h01;
      regen_out <= regen_en_in && (tick < 8'h04);
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in.rd && !ack_out) begin
        if (wait_n >= lat_in) begin
          ack_out <= 1'b1;
          rdata_out <= words[req_in.addr];
          wait_n <= 4'h0;
        end else begin
          wait_n <= wait_n + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/opd_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module opd_control_test;
  import opd_pkg::*;
  logic mclk_in;
  logic nrst_in = 1'b0;
  logic arith_done_in = 1'b0;
  logic [3:0] lat = 4'h0;
  logic mem_regen_in;
  logic mem_ack_in;
  logic [WORD_W-1:0] mem_rdata_in;
  opd_mem_req_t mem_req_out;
  opd_exec_t exec_out;
  logic [INSTR_W-1:0] dec_reg;
  logic [ADDR_W-1:0] cc_out;
  logic busy_out;
  logic saw_rd;
  int miscompares = 0;
  int cmp_count = 0;
  opd_control dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .mem_regen_in(mem_regen_in),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .arith_done_in(arith_done_in),
    .mem_req_out(mem_req_out), .exec_out(exec_out),
    .instruction_decode_register_out(dec_reg), .cc_out(cc_out), .busy_out(busy_out));
  opd_mem_model u_mem (.mclk_in(mclk_in), .nrst_in(nrst_in), .regen_en_in(1'b1),
    .lat_in(lat), .req_in(mem_req_out), .regen_out(mem_regen_in), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  function automatic logic [WORD_W-1:0] val(input logic [ADDR_W-1:0] a);
    return {10'h2a5, a, ~a, a};
  endfunction
  // Unused digit set to one so the decoder must skip it
  function automatic logic [ORDER_W-1:0] mk(input logic [INSTR_W-1:0] i,
      input logic [ADDR_W-1:0] a);
    return {i, 1'b1, a};
  endfunction
  task automatic check(input string what, input logic [WORD_W-1:0] seen,
      input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Wait for read (0), start (1) or answer (2), noting any read on the way
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    saw_rd = 1'b0;
    while (n < 300 && !((k == 0) ? mem_req_out.rd === 1'b1 :
        (k == 1) ? exec_out.start === 1'b1 : mem_ack_in === 1'b1)) begin
      saw_rd = saw_rd | (mem_req_out.rd === 1'b1);
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (n == 300) check("wait", 1'b0, 1'b1);
  endtask
  task automatic fetch(input logic [ADDR_W-1:0] a);
    wait_hi(0);
    check("fetch addr", mem_req_out.addr, a);
    check("fetch busy", busy_out, 1'b1);
    wait_hi(2);
    @(posedge mclk_in);
    #1;
  endtask
  // Kind 0 reads an operand, 1 shifts, 2 uses no memory
  task automatic order(input logic [INSTR_W-1:0] i, input logic [ADDR_W-1:0] a,
      input int kind, input logic [2:0] fl, input logic [ADDR_W-1:0] ecc);
    logic a_ord;
    a_ord = i inside {OP_MQ_ADD_J, OP_MQ_SUB_J, OP_MQ_ADD_ABS_J, OP_MQ_SUB_ABS_J};
    if (kind == 0) begin
      wait_hi(0);
      check("operand addr", mem_req_out.addr, a);
    end
    wait_hi(1);
    if (kind != 0) check("no read", saw_rd, 1'b0);
    check("instr", exec_out.instr, i);
    check("decode reg", dec_reg, i);
    check("addr", exec_out.addr, a);
    check("counter", cc_out, ecc);
    check("busy", busy_out, 1'b1);
    if (kind == 0) check("operand", exec_out.operand, val(a));
    if (kind == 1) check("shift n", exec_out.shift_n, a[SHIFT_W-1:0]);
    if (kind != 1) check("flags", {exec_out.dec.clr_acc, exec_out.dec.negate,
      exec_out.dec.absval}, fl);
    check("mq", {exec_out.dec.clr_mq, exec_out.dec.to_mq}, {2{i == OP_MQ_LOAD}});
    check("a order", {exec_out.dec.jump_after, exec_out.dec.from_mq}, {2{a_ord}});
    if (kind == 1) check("shift dir", exec_out.dec.shift_right, i == OP_SHR);
    @(posedge mclk_in);
    #1;
    check("start", exec_out.start, 1'b0);
    @(posedge mclk_in);
    arith_done_in <= 1'b1;
    @(posedge mclk_in);
    arith_done_in <= 1'b0;
  endtask
  task automatic t_pairs;
    fetch(10'h000);
    order(OP_CLR_ADD, 10'h040, 0, 3'b100, 10'h001);
    order(OP_CLR_SUB, 10'h041, 0, 3'b110, 10'h001);
    fetch(10'h001);
    order(OP_ACC_ADD, 10'h042, 0, 3'b000, 10'h002);
    order(OP_ACC_SUB, 10'h043, 0, 3'b010, 10'h002);
    fetch(10'h002);
    order(OP_CLR_ADD_ABS, 10'h044, 0, 3'b101, 10'h003);
    order(OP_MQ_LOAD, 10'h045, 0, 3'b000, 10'h003);
    $display("pairs test done");
  endtask
  task automatic t_branch;
    lat <= 4'h5;
    fetch(10'h003);
    order(OP_MQ_ADD_J, 10'h008, 2, 3'b100, 10'h004);
    order(OP_SHL, 10'h005, 1, 3'b000, 10'h004);
    fetch(10'h008);
    order(OP_JUMP_LEFT, 10'h00c, 2, 3'b000, 10'h009);
    fetch(10'h00c);
    order(OP_MQ_SUB_J, 10'h010, 2, 3'b110, 10'h00d);
    order(OP_MQ_ADD_ABS_J, 10'h014, 2, 3'b101, 10'h00d);
    fetch(10'h014);
    $display("branch test done");
  endtask
  task automatic t_abs;
    lat <= 4'h1;
    order(OP_CLR_SUB_ABS, 10'h047, 0, 3'b111, 10'h015);
    order(OP_ACC_ADD_ABS, 10'h048, 0, 3'b001, 10'h015);
    fetch(10'h015);
    order(OP_ACC_SUB_ABS, 10'h049, 0, 3'b011, 10'h016);
    order(OP_SHR, 10'h03f, 1, 3'b000, 10'h016);
    fetch(10'h016);
    order(OP_JUMP_RIGHT, 10'h018, 2, 3'b000, 10'h017);
    fetch(10'h018);
    order(OP_CLR_JUMP_LEFT, 10'h01c, 2, 3'b100, 10'h019);
    fetch(10'h01c);
    $display("abs test done");
  endtask
  task automatic t_reset;
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    check("reset cc", cc_out, 10'h000);
    check("reset busy", busy_out, 1'b0);
    check("reset rd", mem_req_out.rd, 1'b0);
    @(posedge mclk_in);
    nrst_in <= 1'b1;
    fetch(10'h000);
    $display("reset test done");
  endtask
  // Program and operands, then the scenarios in turn
  initial begin
    for (int a = 'h40; a < 'h4a; a++) u_mem.words[a] = val(a[ADDR_W-1:0]);
    u_mem.words[0] = {mk(OP_CLR_ADD, 10'h040), mk(OP_CLR_SUB, 10'h041)};
    u_mem.words[1] = {mk(OP_ACC_ADD, 10'h042), mk(OP_ACC_SUB, 10'h043)};
    u_mem.words[2] = {mk(OP_CLR_ADD_ABS, 10'h044), mk(OP_MQ_LOAD, 10'h045)};
    u_mem.words[3] = {mk(OP_MQ_ADD_J, 10'h008), mk(OP_SHL, 10'h005)};
    u_mem.words[8] = {mk(OP_JUMP_LEFT, 10'h00c), mk(OP_CLR_ADD, 10'h046)};
    u_mem.words[12] = {mk(OP_MQ_SUB_J, 10'h010), mk(OP_MQ_ADD_ABS_J, 10'h014)};
    u_mem.words[20] = {mk(OP_CLR_SUB_ABS, 10'h047), mk(OP_ACC_ADD_ABS, 10'h048)};
    u_mem.words[21] = {mk(OP_ACC_SUB_ABS, 10'h049), mk(OP_SHR, 10'h03f)};
    u_mem.words[22] = {mk(OP_JUMP_RIGHT, 10'h018), mk(OP_CLR_ADD, 10'h046)};
    u_mem.words[24] = {mk(OP_SHL_CLR, 10'h001), mk(OP_CLR_JUMP_LEFT, 10'h01c)};
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_pairs;
    t_branch;
    t_abs;
    t_reset;
    stop_test;
  end
  // Watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    #100000;
    check("watchdog", 1'b0, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
